// ==== verilog/pwm_pkg.sv ====
/*
 * Shared constants for the dual-output modulator: special-function register
 * addresses, control field positions, reset values, prescaler limits and
 * the mode encoding.
 * Assumes an 8-bit special-function register space on the processor side.
 */
package pwm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register addresses in the special-function space
    localparam logic [7:0] ADDR_MODULATOR_CONTROL = 8'hae;
    localparam logic [7:0] ADDR_PULSE_WIDTH_LOW = 8'hb1;
    localparam logic [7:0] ADDR_PULSE_WIDTH_HIGH = 8'hb2;
    localparam logic [7:0] ADDR_CYCLE_WIDTH_LOW = 8'hb3;
    localparam logic [7:0] ADDR_CYCLE_WIDTH_HIGH = 8'hb4;

    ////////////////////////////////////////////////////////////////////////
    // Control register layout
    localparam int MODE_MSB = 6;
    localparam int MODE_LSB = 4;
    localparam int DIV_MSB = 3;
    localparam int DIV_LSB = 2;
    localparam int SRC_MSB = 1;
    localparam int SRC_LSB = 0;
    localparam logic [7:0] CONTROL_WRITE_MASK = 8'h7f; // Bit 7 not implemented

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler terminal counts for divide by 1, 4, 16 and 64
    localparam logic [5:0] DIV_LIMIT_1 = 6'h00;
    localparam logic [5:0] DIV_LIMIT_4 = 6'h03;
    localparam logic [5:0] DIV_LIMIT_16 = 6'h0f;
    localparam logic [5:0] DIV_LIMIT_64 = 6'h3f;

    ////////////////////////////////////////////////////////////////////////
    // Counter limits
    localparam logic [15:0] FULL_COUNT = 16'hffff;
    localparam logic [15:0] COUNT_ONE = 16'h0001;

    ////////////////////////////////////////////////////////////////////////
    // Operating modes as held in the control register
    typedef enum logic [2:0] {
        MODE_OFF = 3'h0,
        MODE_SINGLE16 = 3'h1,
        MODE_TWIN8 = 3'h2,
        MODE_TWIN16 = 3'h3,
        MODE_NRZ = 3'h4,
        MODE_DUAL8 = 3'h5,
        MODE_RZ = 3'h6,
        MODE_HOLD = 3'h7
    } mode_type;

endpackage : pwm_pkg

// ==== verilog/pwm_tick_if.sv ====
/*
 * Bundle between the modulator core and its prescaler: divider select,
 * restart request, divided tick and the first-half phase flag.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps

interface pwm_tick_if;
    logic [1:0] div_sel;  // Divider code from control
    logic restart;        // Clears the prescaler phase
    logic tick;           // One-cycle pulse per PWM clock
    logic first_half;     // High during the first half of a PWM clock

    modport gen (input div_sel, input restart, output tick, output first_half);
    modport use_side (output div_sel, output restart, input tick, input first_half);
endinterface : pwm_tick_if

// ==== verilog/pwm_prescaler.sv ====
/*
 * Divides the selected PWM source tick by 1, 4, 16 or 64 and reports the
 * phase inside each divided clock.
 * Assumes src_tick_i is a one-cycle pulse synchronous to clk_sys_i.
 */
`timescale 1ns/1ps

module pwm_prescaler
    import pwm_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic src_tick_i,
    pwm_tick_if.gen tick_if
);

    logic [5:0] phase_q; // Source ticks seen in this PWM clock
    logic [5:0] limit;   // Terminal count for the chosen divider

    ////////////////////////////////////////////////////////////////////////
    // Divider decode
    always_comb begin
        case (tick_if.div_sel)
            2'h0: limit = DIV_LIMIT_1;
            2'h1: limit = DIV_LIMIT_4;
            2'h2: limit = DIV_LIMIT_16;
            default: limit = DIV_LIMIT_64;
        endcase
    end

    // Phase counter, restarted with the main counter
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || tick_if.restart) begin
            phase_q <= 6'h00;
        end else if (src_tick_i) begin
            phase_q <= (phase_q == limit) ? 6'h00 : phase_q + 6'h01;
        end
    end

    assign tick_if.tick = src_tick_i && (phase_q == limit);
    // Divide by 1 cannot be halved, so the whole clock counts as first half;
    // halving before the add keeps divide by 64 from overflowing six bits
    assign tick_if.first_half = (limit == DIV_LIMIT_1) ||
        (phase_q < ((limit >> 1) + 6'h01));

endmodule : pwm_prescaler

// ==== verilog/pwm_density_acc.sv ====
/*
 * First-order pulse-density accumulator: adds its value on every step and
 * reports the carry as the output bit for that PWM clock.
 * Assumes step_i is a one-cycle pulse and value_i is stable between steps.
 */
`timescale 1ns/1ps

module pwm_density_acc #(
    parameter int WIDTH = 16
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic clear_i,
    input wire logic step_i,
    input wire logic [WIDTH-1:0] value_i,
    output logic carry_o
);

    logic [WIDTH-1:0] acc_q; // Running residue
    logic [WIDTH:0] sum;     // Residue plus value with carry

    assign sum = {1'b0, acc_q} + {1'b0, value_i};

    ////////////////////////////////////////////////////////////////////////
    // Accumulate; carry spreads high clocks evenly over the window
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || clear_i) begin
            acc_q <= '0;
            carry_o <= 1'b0;
        end else if (step_i) begin
            acc_q <= sum[WIDTH-1:0];
            carry_o <= sum[WIDTH];
        end
    end

endmodule : pwm_density_acc

// ==== verilog/dual_output_pwm_sigma_delta.sv ====
/*
 * Dual-output pulse-width and pulse-density modulator with its control and
 * data registers on the special-function register port.
 * Assumes a processor SFR port synchronous to clk_sys_i and a selected PWM
 * source tick supplied from outside; the source mux itself lives elsewhere.
 */
// How it works
// - Mode zero: idle, both pins released
// - Single mode: cycle pair sets period
// - Single mode: pulse pair sets duty
// - Twin 8-bit: cycle low byte sets period
// - Twin 8-bit: first falls at pulse low
// - Twin 8-bit: second rises/falls at high bytes
// - Twin 16-bit: counter spans full 16 bits
// - Twin 16-bit: first high below pulse pair
// - Twin 16-bit: second high below cycle pair
// - Twin 16-bit: both rise together at zero
// - NRZ density: high exactly value clocks per window
// - Density highs spread evenly, sigma-delta style
// - RZ density: high only first half-clock when divided above 1
// - Dual 8-bit: independent periods and duties
// - Dual 8-bit: low bytes first, high second
// - One clock source and prescaler for both
// - Mode seven: outputs off, pins released
// - Control bits 6..4 select eight modes
// - Control write resets the counter
// - Low byte held in 16-bit modes; high write commits, pair used from next cycle end
`timescale 1ns/1ps

module dual_output_pwm_sigma_delta
    import pwm_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic pwm_src_tick_i,
    output logic [7:0] sfr_rdata_o,
    output logic [1:0] clk_source_sel_o,
    output logic first_output_o,
    output logic second_output_o,
    output logic first_output_pin_sel_o,
    output logic second_output_pin_sel_o,
    output logic alt_first_output_pin_sel_o,
    output logic alt_second_output_pin_sel_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0] control_q;      // Mode, divider and source fields
    logic [7:0] pulse_low_q;    // Visible pulse low byte
    logic [7:0] pulse_high_q;   // Visible pulse high byte
    logic [7:0] cycle_low_q;    // Visible cycle low byte
    logic [7:0] cycle_high_q;   // Visible cycle high byte
    logic [7:0] pulse_hold_q;   // Hidden low byte awaiting commit
    logic [7:0] cycle_hold_q;   // Hidden low byte awaiting commit
    logic [15:0] act_pulse_q;   // Pulse pair in use this cycle
    logic [15:0] act_cycle_q;   // Cycle pair in use this cycle
    logic [15:0] count_q;       // Shared PWM counter
    logic [7:0] count2_q;       // Second counter, dual 8-bit only
    logic twin_second_q;        // Set/reset state of second twin output
    logic [1:0] carry;          // Density accumulator bits
    logic [15:0] density_val [2]; // Values fed to the accumulators
    mode_type mode;             // Decoded mode field
    logic wide_mode;            // A 16-bit mode is selected
    logic running;              // Counter is allowed to move
    logic control_wr;           // Control register write strobe
    logic wrap;                 // Main counter ends its cycle this tick
    logic wrap2;                // Second counter ends its cycle this tick
    logic first_d;
    logic second_d;
    logic [3:0] sel_d;          // Pin ownership: first, second, alt first, alt second
    logic [7:0] read_mux;

    pwm_tick_if tick_if ();

    ////////////////////////////////////////////////////////////////////////
    // Mode decode
    assign mode = mode_type'(control_q[MODE_MSB:MODE_LSB]);
    assign wide_mode = (mode == MODE_SINGLE16) || (mode == MODE_TWIN16) ||
        (mode == MODE_NRZ) || (mode == MODE_RZ);
    // Modes 0 and 7 both park the counter at zero
    assign running = (mode != MODE_OFF) && (mode != MODE_HOLD);
    assign control_wr = sfr_wr_i && (sfr_addr_i == ADDR_MODULATOR_CONTROL);

    ////////////////////////////////////////////////////////////////////////
    // Control register; bit 7 is not implemented and reads zero
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            control_q <= CONTROL_RESET;
        end else if (control_wr) begin
            control_q <= sfr_wdata_i & CONTROL_WRITE_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data registers; in 16-bit modes the low byte waits in a hidden
    // register so the pair never changes half-way between two writes
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            pulse_low_q <= DATA_RESET;
            pulse_high_q <= DATA_RESET;
            cycle_low_q <= DATA_RESET;
            cycle_high_q <= DATA_RESET;
            pulse_hold_q <= DATA_RESET;
            cycle_hold_q <= DATA_RESET;
        end else if (sfr_wr_i) begin
            case (sfr_addr_i)
                ADDR_PULSE_WIDTH_LOW: begin
                    if (wide_mode) begin
                        pulse_hold_q <= sfr_wdata_i;
                    end else begin
                        pulse_low_q <= sfr_wdata_i;
                    end
                end
                ADDR_PULSE_WIDTH_HIGH: begin
                    pulse_high_q <= sfr_wdata_i;
                    if (wide_mode) begin
                        pulse_low_q <= pulse_hold_q;
                    end
                end
                ADDR_CYCLE_WIDTH_LOW: begin
                    if (wide_mode) begin
                        cycle_hold_q <= sfr_wdata_i;
                    end else begin
                        cycle_low_q <= sfr_wdata_i;
                    end
                end
                ADDR_CYCLE_WIDTH_HIGH: begin
                    cycle_high_q <= sfr_wdata_i;
                    if (wide_mode) begin
                        cycle_low_q <= cycle_hold_q;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port; answer lands one cycle after the read strobe
    always_comb begin
        case (sfr_addr_i)
            ADDR_MODULATOR_CONTROL: read_mux = control_q;
            ADDR_PULSE_WIDTH_LOW: read_mux = pulse_low_q;
            ADDR_PULSE_WIDTH_HIGH: read_mux = pulse_high_q;
            ADDR_CYCLE_WIDTH_LOW: read_mux = cycle_low_q;
            ADDR_CYCLE_WIDTH_HIGH: read_mux = cycle_high_q;
            default: read_mux = READ_UNMAPPED; // Unmapped reads as zero
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            sfr_rdata_o <= READ_UNMAPPED;
        end else if (sfr_rd_i) begin
            sfr_rdata_o <= read_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One prescaler serves both outputs; there is no per-output clock
    assign tick_if.div_sel = control_q[DIV_MSB:DIV_LSB];
    assign tick_if.restart = control_wr || !running;

    pwm_prescaler u_prescaler (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .src_tick_i(pwm_src_tick_i),
        .tick_if(tick_if)
    );

    // Source select is only exported; the external mux picks the clock
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            clk_source_sel_o <= 2'h0;
        end else begin
            clk_source_sel_o <= control_q[SRC_MSB:SRC_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // End-of-cycle detection per mode
    always_comb begin
        case (mode)
            // Period register gives the cycle length; zero means 65536
            MODE_SINGLE16: wrap = (count_q == act_cycle_q - COUNT_ONE);
            MODE_TWIN8: wrap = (count_q[7:0] == act_cycle_q[7:0]);
            MODE_DUAL8: wrap = (count_q[7:0] == act_cycle_q[7:0]);
            default: wrap = (count_q == FULL_COUNT);
        endcase
    end

    assign wrap2 = (count2_q == act_cycle_q[15:8]);

    ////////////////////////////////////////////////////////////////////////
    // Shared counter; control writes restart it from zero
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || control_wr || !running) begin
            count_q <= 16'h0000;
        end else if (tick_if.tick) begin
            count_q <= wrap ? 16'h0000 : count_q + COUNT_ONE;
        end
    end

    // Independent second counter for the dual 8-bit mode
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || control_wr || mode != MODE_DUAL8) begin
            count2_q <= 8'h00;
        end else if (tick_if.tick) begin
            count2_q <= wrap2 ? 8'h00 : count2_q + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Working copies reload only at a main-counter cycle boundary or a restart, so a new
    // value never cuts into a main-counter cycle; a dual 8-bit second cycle can be cut
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            act_pulse_q <= 16'h0000;
            act_cycle_q <= 16'h0000;
        end else if (control_wr || !running || (tick_if.tick && wrap)) begin
            act_pulse_q <= {pulse_high_q, pulse_low_q};
            act_cycle_q <= {cycle_high_q, cycle_low_q};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Twin 8-bit second output: rises at the cycle high byte, falls at
    // the pulse high byte; the fall wins when both match
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || control_wr || mode != MODE_TWIN8) begin
            twin_second_q <= 1'b0;
        end else if (tick_if.tick) begin
            if (count_q[7:0] == act_pulse_q[15:8]) begin
                twin_second_q <= 1'b0;
            end else if (count_q[7:0] == act_cycle_q[15:8]) begin
                twin_second_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pulse-density accumulators, one per output
    assign density_val[0] = act_pulse_q;
    assign density_val[1] = act_cycle_q;

    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_density
            pwm_density_acc #(
                .WIDTH(16)
            ) u_acc (
                .clk_sys_i(clk_sys_i),
                .reset_n_i(reset_n_i),
                .clear_i(control_wr || !(mode == MODE_NRZ || mode == MODE_RZ)),
                .step_i(tick_if.tick),
                .value_i(density_val[ch]),
                .carry_o(carry[ch])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Output selection per mode
    always_comb begin
        first_d = 1'b0;
        second_d = 1'b0;
        sel_d = 4'h0; // Pins released unless a mode claims them
        case (mode)
            MODE_SINGLE16: begin
                first_d = (count_q < act_pulse_q);
                sel_d = 4'h1;
            end
            MODE_TWIN8: begin
                first_d = (count_q[7:0] < act_pulse_q[7:0]);
                second_d = twin_second_q;
                sel_d = 4'h3;
            end
            MODE_TWIN16: begin
                // Both go high together when the counter is back at zero
                first_d = (count_q < act_pulse_q);
                second_d = (count_q < act_cycle_q);
                sel_d = 4'h3;
            end
            MODE_NRZ: begin
                first_d = carry[0];
                second_d = carry[1];
                sel_d = 4'hc;        // NRZ density output uses the alternate pins
            end
            MODE_DUAL8: begin
                first_d = (count_q[7:0] < act_pulse_q[7:0]);
                second_d = (count2_q < act_pulse_q[15:8]);
                sel_d = 4'h3;
            end
            MODE_RZ: begin
                // Needs a divider above 1 to have a second half at all
                first_d = carry[0] && tick_if.first_half;
                second_d = carry[1] && tick_if.first_half;
                sel_d = 4'h3;
            end
            default: begin
                sel_d = 4'h0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Output flops
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            first_output_o <= 1'b0;
            second_output_o <= 1'b0;
            first_output_pin_sel_o <= 1'b0;
            second_output_pin_sel_o <= 1'b0;
            alt_first_output_pin_sel_o <= 1'b0;
            alt_second_output_pin_sel_o <= 1'b0;
        end else begin
            first_output_o <= first_d;
            second_output_o <= second_d;
            first_output_pin_sel_o <= sel_d[0];
            second_output_pin_sel_o <= sel_d[1];
            alt_first_output_pin_sel_o <= sel_d[2];
            alt_second_output_pin_sel_o <= sel_d[3];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_idle_release;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (mode == MODE_OFF) |=> !first_output_pin_sel_o && !second_output_pin_sel_o &&
            !alt_first_output_pin_sel_o && !alt_second_output_pin_sel_o;
    endproperty
    a_idle_release: assert property (p_idle_release)
        else $error("pins claimed in mode zero");

    property p_hold_release;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (mode == MODE_HOLD) |=> !first_output_o && !second_output_o &&
            !first_output_pin_sel_o && !second_output_pin_sel_o && count_q == 16'h0000;
    endproperty
    a_hold_release: assert property (p_hold_release)
        else $error("mode seven left outputs or counter active");

    property p_ctrl_resets;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        control_wr |=> (count_q == 16'h0000);
    endproperty
    a_ctrl_resets: assert property (p_ctrl_resets)
        else $error("control write did not reset counter");

    property p_low_held;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (sfr_wr_i && wide_mode && sfr_addr_i == ADDR_PULSE_WIDTH_LOW) |=>
            $stable(pulse_low_q) && (pulse_hold_q == $past(sfr_wdata_i));
    endproperty
    a_low_held: assert property (p_low_held)
        else $error("low byte bypassed the hidden register");

    property p_full_wrap;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (mode == MODE_TWIN16 && tick_if.tick && count_q == FULL_COUNT && !control_wr)
            |=> (count_q == 16'h0000) ##1 ((first_output_o == ($past(act_pulse_q) != 16'h0000)) &&
            (second_output_o == ($past(act_cycle_q) != 16'h0000)));
    endproperty
    a_full_wrap: assert property (p_full_wrap)
        else $error("twin 16-bit counter wrap wrong");

    property p_step;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (running && tick_if.tick && !wrap && !control_wr) |=>
            (count_q == $past(count_q) + COUNT_ONE);
    endproperty
    a_step: assert property (p_step)
        else $error("counter did not advance on tick");

    property p_rz_half;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (mode == MODE_RZ && !tick_if.first_half) |=> !first_output_o && !second_output_o;
    endproperty
    a_rz_half: assert property (p_rz_half)
        else $error("RZ output high in second half");

    property p_nrz_carry;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (mode == MODE_NRZ && !control_wr) |=> (second_output_o == $past(carry[1])) &&
            alt_second_output_pin_sel_o;
    endproperty
    a_nrz_carry: assert property (p_nrz_carry)
        else $error("NRZ output not from accumulator");

endmodule : dual_output_pwm_sigma_delta

// ==== tb/dual_output_pwm_sigma_delta_test.sv ====
/* Self-checking bench for the dual-output modulator: registers, pins, waveforms.
   Assumes the source tick is held high, so the PWM clock runs at the sys rate unless the divider field selects 4. */
`timescale 1ns/1ps
module dual_output_pwm_sigma_delta_test;
    import pwm_pkg::*;
    logic clk_sys_i, reset_n_i, sfr_wr_i, sfr_rd_i, pwm_src_tick_i;
    logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, rd_q, lf;
    logic [1:0] clk_source_sel_o;
    logic first_output_o, second_output_o, first_output_pin_sel_o, second_output_pin_sel_o;
    logic alt_first_output_pin_sel_o, alt_second_output_pin_sel_o;
    logic [31:0] h1, h2; // High-clock tallies of the two outputs
    int failures, checks;
    dual_output_pwm_sigma_delta dual_output_pwm_sigma_delta_inst (.*);
    ////////////////////////////////////////////////////////////////////////
    // Free-running system clock
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    // Random bytes, repeatable from the fixed start value
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp8
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp32
    // Pin ownership {first, second, alt first, alt second} per mode code
    function automatic logic [7:0] pins_exp(input int m);
        case (m)
            1: return 8'h08;
            2, 3, 5, 6: return 8'h0c;
            4: return 8'h03;
            default: return 8'h00;
        endcase
    endfunction : pins_exp
    // Bus cycles start 1 ns after an edge, after one idle edge, and hold
    // through the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        #1 sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        @(posedge clk_sys_i);
        #1 sfr_wr_i = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_i);
        #1 sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        @(posedge clk_sys_i);
        #1 sfr_rd_i = 1'b0;
        rd_q = sfr_rdata_o;
    endtask : rd
    // Tally highs over n clocks; any whole-period window gives the duty
    task automatic tally(input int n);
        h1 = 0;
        h2 = 0;
        repeat (n) begin
            @(posedge clk_sys_i);
            #1 h1 += first_output_o;
            h2 += second_output_o;
        end
    endtask : tally
    // Mode first, pairs low then high, mode again so working copies reload
    task automatic prog(input logic [2:0] m, input logic [15:0] p, input logic [15:0] c);
        wr(ADDR_MODULATOR_CONTROL, {1'b0, m, 4'h0});
        wr(ADDR_PULSE_WIDTH_LOW, p[7:0]);
        wr(ADDR_PULSE_WIDTH_HIGH, p[15:8]);
        wr(ADDR_CYCLE_WIDTH_LOW, c[7:0]);
        wr(ADDR_CYCLE_WIDTH_HIGH, c[15:8]);
        wr(ADDR_MODULATOR_CONTROL, {1'b0, m, 4'h0});
        tally(8);
    endtask : prog
    task automatic give_verdict();
        if (failures == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    // Hang guard, about half again beyond the longest expected run
    initial begin
        #(100000 * 8);
        failures++;
        give_verdict();
    end
    initial begin
        failures = 0;
        checks = 0;
        lf = 8'h35;
        {reset_n_i, sfr_wr_i, sfr_rd_i, sfr_addr_i, sfr_wdata_i} = '0;
        pwm_src_tick_i = 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1 reset_n_i = 1'b1;
        // Reset values, unmapped holes at 0xaf and 0xb0 read zero
        wr(8'hb0, lf);
        for (int a = 8'hae; a <= 8'hb4; a++) begin
            rd(a[7:0]);
            cmp8(rd_q, 8'h00);
        end
        // Every mode code, bit 7 dropped, pins free in modes 0 and 7
        for (int m = 0; m < 8; m++) begin
            wr(ADDR_MODULATOR_CONTROL, {1'b1, m[2:0], 4'h6});
            rd(ADDR_MODULATOR_CONTROL);
            cmp8(rd_q, {1'b0, m[2:0], 4'h6});
            cmp8({4'h0, first_output_pin_sel_o, second_output_pin_sel_o,
                alt_first_output_pin_sel_o, alt_second_output_pin_sel_o}, pins_exp(m));
            cmp8({6'h00, clk_source_sel_o}, 8'h02);
        end
        // Held low byte stays hidden until the high byte commits
        lf = lfsr_next(lf);
        wr(ADDR_MODULATOR_CONTROL, 8'h10);
        wr(ADDR_PULSE_WIDTH_LOW, lf);
        rd(ADDR_PULSE_WIDTH_LOW);
        cmp8(rd_q, 8'h00);
        wr(ADDR_PULSE_WIDTH_HIGH, 8'h00);
        rd(ADDR_PULSE_WIDTH_LOW);
        cmp8(rd_q, lf);
        // Single mode, random period and duty
        repeat (4) begin
            lf = lfsr_next(lf);
            prog(3'h1, {10'h0, lf[7:2]}, {10'h0, lf[5:0]} + 16'h0041);
            tally(lf[5:0] + 65);
            cmp32(h1, {26'h0, lf[7:2]});
            cmp32(h2, 0);
        end
        prog(3'h2, 16'h0603, 16'h0209); // Rise at cycle high byte 2, fall at pulse high byte 6
        tally(10);
        cmp32(h1, 3);
        cmp32(h2, 4);
        prog(3'h5, 16'h0201, 16'h0403); // Periods of 4 and 5 clocks, window 20
        tally(20);
        cmp32(h1, 5);
        cmp32(h2, 8);
        // Counter restarts at zero, so this window sees counts 8 to 71
        prog(3'h3, 16'h0030, 16'h0020);
        tally(64);
        cmp32(h1, 32'd40);
        cmp32(h2, 32'd24);
        // Quarter and half scale repeat every 4 and 2 PWM clocks
        prog(3'h6, 16'h4000, 16'h8000);
        wr(ADDR_MODULATOR_CONTROL, 8'h64);
        tally(16);
        tally(64);
        cmp32(h1, 32'd8);
        cmp32(h2, 32'd16);
        prog(3'h4, 16'h4010, 16'h0401);
        tally(65536);
        cmp32(h1, 32'h4010);
        cmp32(h2, 32'h0401);
        give_verdict();
    end
endmodule : dual_output_pwm_sigma_delta_test
